// ---- rtl/sp_pkg.sv ----
// Purpose: constants and state type of the serial port block
// Assumes: register index = byte address / 4 on the bus
// Notes:   the system clock is taken as the oscillator
package sp_pkg;

    // ************************************************************
    // register indices and fields
    // ************************************************************
    localparam logic [7:0] IDX_POWER_CTRL  = 8'h87;
    localparam logic [7:0] IDX_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] IDX_DATA_BUF    = 8'h99;
    localparam logic [7:0] IDX_BAUD_SRC    = 8'hA0;

    localparam int PC_BAUD_DBL = 7;
    localparam int SC_REN      = 4;
    localparam int BS_SIX_T    = 0;
    localparam int BS_RX_T2    = 1;
    localparam int BS_TX_T2    = 2;

    localparam logic [7:0] RST_POWER_CTRL  = 8'h00;
    localparam logic [7:0] RST_SERIAL_CTRL = 8'h00;
    localparam logic [7:0] RST_DATA_BUF    = 8'h00;
    localparam logic [2:0] RST_BAUD_SRC    = 3'h0;

    // ************************************************************
    // modes and timing
    // ************************************************************
    localparam logic [1:0] MODE_SYNC  = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_UART9 = 2'h2;

    localparam logic [3:0] M0_DIV_12T = 4'hC;
    localparam logic [3:0] M0_DIV_6T  = 4'h6;
    localparam logic [3:0] M0_BITS    = 4'h8;
    localparam logic [2:0] OSR_LAST   = 3'h7;
    localparam logic [2:0] SAMPLE_PH  = 3'h3;
    localparam logic [3:0] FRAME_M1   = 4'hA;
    localparam logic [3:0] FRAME_M2   = 4'hB;
    localparam logic [3:0] DECIDE_BIT = 4'h9;

    typedef enum logic [1:0] {
        XF_IDLE  = 2'b00,
        XF_ASYNC = 2'b01,
        XF_SYNC  = 2'b10
    } sp_xfer_t;

    typedef struct packed {
        logic        ack;
        logic [7:0]  rdat;
        logic [1:0]  mode;
        logic        mpc;
        logic        ren;
        logic        tx_ninth_bit;
        logic        rx_ninth_bit;
        logic        tx_done_flag;
        logic        rx_done_flag;
        logic        baud_double;
        logic [4:0]  pbits;
        logic        six_t;
        logic        rsel2;
        logic        tsel2;
        logic [7:0]  rbuf;
        sp_xfer_t    tx_st;
        logic [10:0] tsh;
        logic [3:0]  tbits;
        logic [2:0]  tph;
        logic [2:0]  tpre;
        sp_xfer_t    rx_st;
        logic [8:0]  rsh;
        logic [3:0]  rbits;
        logic [2:0]  rph;
        logic [2:0]  rpre;
        logic        rxd_d;
        logic [3:0]  m0cnt;
        logic        txd;
        logic        rxd_o;
        logic        rxd_oe;
    } sp_state_t;

endpackage : sp_pkg

// ---- rtl/sp_uart.sv ----
// Purpose: serial port, modes 0 to 3, with a Wishbone register slave
// Assumes: pins and timer overflow pulses are synchronous to I_SYS_CLK
// Notes:   asynchronous modes run an 8x oversampling bit clock
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - baud double doubles mode 2 rate, and modes 1/3 on timer 1 only
// - data buffer write feeds transmitter; read returns receive register
// - mode 0 moves data on receive pin, clock on transmit pin
// - mode 0 shift clock is oscillator over 12, or over 6
// - mode 0 clock always comes from the device; partner only follows
// - mode 0 shifts least significant bit first, one per shift clock
// - mode 0 buffer write shifts eight bits then sets transmit done
// - mode 0 receive starts on enable rising with receive done clear
// - mode 1 frame: start 0, eight data bits LSB first, stop 1
// - mode 1 rate from timer 1 or timer 2, chosen per direction
// - mode 1 write sends full frame; transmit done after stop bit
// - mode 1 reception starts on falling receive pin when enabled
// - mode 1 mid stop: load if done clear and stop check passes
// - after every asynchronous reception the receiver waits for new edge
// - mode 2 frame: start, eight data, ninth bit, stop
// - mode 2 rate is oscillator over 64 or 32; 6T halves divisors
// - mode 2 write sends data, ninth bit, stop; then transmit done
// - mode 2 reception starts on start bit edge, decides mid ninth bit
// - mode 2 decision: load if done clear and ninth bit check passes
module sp_uart
    import sp_pkg::*;
(
    // clock and reset
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESETN,
    // wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [9:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output logic      [31:0] O_WB_DAT,
    output logic             O_WB_ACK,
    // baud sources
    input  wire logic        I_T1_OVF,
    input  wire logic        I_T2_OVF,
    // serial pins
    input  wire logic        I_RXD,
    output logic             O_RXD,
    output logic             O_RXD_OE,
    output logic             O_TXD
);

    // ************************************************************
    // rate helpers
    // ************************************************************
    // returns {source pulse, prescale shift} for the 8x bit clock
    function automatic logic [2:0] sp_rate(
        input logic [1:0] mode,
        input logic       baud_double,
        input logic       six,
        input logic       sel2,
        input logic       t1,
        input logic       t2
    );
        logic [1:0] sh;
        logic       src;
        sh  = 2'h0;
        src = 1'b0;
        if (mode == MODE_UART9)
        begin
            src = 1'b1;
            sh  = 2'h3 - {1'b0, baud_double} - {1'b0, six};
        end
        else if (sel2)
        begin
            src = t2;
            sh  = 2'h1 - {1'b0, six};
        end
        else
        begin
            src = t1;
            sh  = 2'h2 - {1'b0, baud_double} - {1'b0, six};
        end
        return {src, sh};
    endfunction : sp_rate

    function automatic logic sp_tick(
        input logic [2:0] rate,
        input logic [2:0] pre
    );
        logic [2:0] mask;
        mask = (3'h1 << rate[1:0]) - 3'h1;
        return rate[2] && ((pre & mask) == mask);
    endfunction : sp_tick

    // ************************************************************
    // state
    // ************************************************************
    sp_state_t  q;
    sp_state_t  n;
    logic       req;
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wd;

    assign req = I_WB_CYC & I_WB_STB;
    assign wr  = req & q.ack & I_WB_WE & I_WB_SEL[0];
    assign idx = I_WB_ADR[9:2];
    assign wd  = I_WB_DAT[7:0];

    always_comb
    begin
        logic [2:0] trate;
        logic [2:0] rrate;
        logic       ttick;
        logic       rtick;
        logic [3:0] m0div;
        logic [3:0] m0half;
        logic       m0wrap;
        logic [3:0] flen;
        logic       tload;
        trate  = sp_rate(q.mode, q.baud_double, q.six_t, q.tsel2,
                         I_T1_OVF, I_T2_OVF);
        rrate  = sp_rate(q.mode, q.baud_double, q.six_t, q.rsel2,
                         I_T1_OVF, I_T2_OVF);
        ttick  = sp_tick(trate, q.tpre);
        rtick  = sp_tick(rrate, q.rpre);
        m0div  = q.six_t ? M0_DIV_6T : M0_DIV_12T;
        m0half = m0div >> 1;
        m0wrap = (q.m0cnt == m0div - 4'h1);
        flen   = (q.mode == MODE_UART8) ? FRAME_M1 : FRAME_M2;
        tload  = wr && (idx == IDX_DATA_BUF);
        n      = q;

        // ********************************************************
        // bus slave
        // ********************************************************
        // answer one cycle after the request; a write lands one cycle later, at the edge that drops ack
        n.ack  = req & ~q.ack;
        n.rdat = 8'h00;
        if (req && !q.ack && !I_WB_WE)
        begin
            unique case (idx)
                IDX_POWER_CTRL:
                    n.rdat = {q.baud_double, 2'h0, q.pbits};
                IDX_SERIAL_CTRL:
                    n.rdat = {q.mode, q.mpc, q.ren, q.tx_ninth_bit,
                              q.rx_ninth_bit, q.tx_done_flag,
                              q.rx_done_flag};
                IDX_DATA_BUF:
                    n.rdat = q.rbuf;
                IDX_BAUD_SRC:
                    n.rdat = {5'h00, q.tsel2, q.rsel2, q.six_t};
                default:
                    n.rdat = 8'h00;
            endcase
        end
        if (wr)
        begin
            unique case (idx)
                IDX_POWER_CTRL:
                begin
                    n.baud_double = wd[PC_BAUD_DBL];
                    n.pbits       = wd[4:0];
                end
                IDX_SERIAL_CTRL:
                begin
                    {n.mode, n.mpc, n.ren, n.tx_ninth_bit,
                     n.rx_ninth_bit, n.tx_done_flag,
                     n.rx_done_flag} = wd;
                    // clear-then-set of the enable opens a sync read
                    if (q.mode == MODE_SYNC && wd[7:6] == MODE_SYNC
                        && wd[SC_REN] && !q.ren && !q.rx_done_flag
                        && !wd[0]
                        && q.rx_st == XF_IDLE && q.tx_st == XF_IDLE)
                    begin
                        n.rx_st = XF_SYNC;
                        n.rbits = 4'h0;
                        n.m0cnt = 4'h0;
                        n.txd   = 1'b0;
                        n.rxd_oe = 1'b0;
                    end
                end
                IDX_DATA_BUF:
                begin
                    // a write during a frame restarts the transmitter
                    if (q.mode == MODE_SYNC)
                    begin
                        if (q.rx_st == XF_IDLE)
                        begin
                            n.tx_st  = XF_SYNC;
                            n.tsh    = {3'h7, wd};
                            n.tbits  = 4'h0;
                            n.m0cnt  = 4'h0;
                            n.txd    = 1'b0;
                            n.rxd_o  = wd[0];
                            n.rxd_oe = 1'b1;
                        end
                    end
                    else
                    begin
                        n.tx_st = XF_ASYNC;
                        n.tsh   = (q.mode == MODE_UART8)
                                ? {2'h3, wd, 1'b0}
                                : {1'b1, q.tx_ninth_bit, wd, 1'b0};
                        n.tbits = 4'h0;
                        n.tph   = 3'h0;
                        n.txd   = 1'b0;
                    end
                end
                IDX_BAUD_SRC:
                    {n.tsel2, n.rsel2, n.six_t} = wd[2:0];
                default:
                    n.ack = n.ack;
            endcase
        end

        // ********************************************************
        // prescalers and pin history
        // ********************************************************
        n.tpre  = q.tpre + {2'h0, trate[2]};
        n.rpre  = q.rpre + {2'h0, rrate[2]};
        n.rxd_d = I_RXD;

        // ********************************************************
        // transmitter
        // ********************************************************
        // a buffer write owns this cycle, so a running frame cannot
        // overwrite the freshly loaded shifter
        if (!tload)
        unique case (q.tx_st)
            XF_IDLE:
                n.tph = q.tph;
            XF_ASYNC:
            begin
                if (ttick)
                begin
                    n.tph = q.tph + 3'h1;
                    if (q.tph == OSR_LAST)
                    begin
                        n.tbits = q.tbits + 4'h1;
                        n.tsh   = {1'b1, q.tsh[10:1]};
                        n.txd   = q.tsh[1];
                        if (q.tbits == flen - 4'h1)
                        begin
                            n.tx_st = XF_IDLE;
                            n.txd   = 1'b1;
                            n.tx_done_flag = 1'b1;
                        end
                    end
                end
            end
            XF_SYNC:
            begin
                n.m0cnt = m0wrap ? 4'h0 : q.m0cnt + 4'h1;
                n.txd   = (n.m0cnt >= m0half);
                if (m0wrap)
                begin
                    n.tbits = q.tbits + 4'h1;
                    n.tsh   = {1'b1, q.tsh[10:1]};
                    n.rxd_o = q.tsh[1];
                    if (q.tbits == M0_BITS - 4'h1)
                    begin
                        n.tx_st  = XF_IDLE;
                        n.txd    = 1'b1;
                        n.rxd_oe = 1'b0;
                        n.rxd_o  = 1'b0;
                        n.tx_done_flag = 1'b1;
                    end
                end
            end
            default:
                n.tx_st = XF_IDLE;
        endcase

        // ********************************************************
        // receiver
        // ********************************************************
        unique case (q.rx_st)
            XF_IDLE:
            begin
                if (q.mode != MODE_SYNC && q.ren && q.rxd_d && !I_RXD)
                begin
                    n.rx_st = XF_ASYNC;
                    n.rph   = 3'h0;
                    n.rbits = 4'h0;
                end
            end
            XF_ASYNC:
            begin
                // dropping the enable abandons the frame
                if (!q.ren || q.mode == MODE_SYNC)
                    n.rx_st = XF_IDLE;
                else if (rtick)
                begin
                    n.rph = q.rph + 3'h1;
                    if (q.rph == OSR_LAST)
                        n.rbits = q.rbits + 4'h1;
                    if (q.rph == SAMPLE_PH)
                    begin
                        if (q.rbits == 4'h0)
                        begin
                            // a glitch, not a start bit
                            if (I_RXD)
                                n.rx_st = XF_IDLE;
                        end
                        else if (q.rbits == DECIDE_BIT)
                        begin
                            if (!q.rx_done_flag && (!q.mpc || I_RXD))
                            begin
                                n.rbuf = q.rsh[8:1];
                                n.rx_ninth_bit = I_RXD;
                                n.rx_done_flag = 1'b1;
                            end
                            n.rx_st = XF_IDLE;
                        end
                        else
                            n.rsh = {I_RXD, q.rsh[8:1]};
                    end
                end
            end
            XF_SYNC:
            begin
                n.m0cnt = m0wrap ? 4'h0 : q.m0cnt + 4'h1;
                n.txd   = (n.m0cnt >= m0half);
                // sample on the rising shift clock edge
                if (n.m0cnt == m0half)
                    n.rsh = {I_RXD, q.rsh[8:1]};
                if (m0wrap)
                begin
                    n.rbits = q.rbits + 4'h1;
                    if (q.rbits == M0_BITS - 4'h1)
                    begin
                        n.rx_st = XF_IDLE;
                        n.txd   = 1'b1;
                        n.rbuf  = q.rsh[8:1];
                        n.rx_done_flag = 1'b1;
                    end
                end
            end
            default:
                n.rx_st = XF_IDLE;
        endcase
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN)
        begin
            q       <= '0;
            q.txd   <= 1'b1;
            q.rxd_d <= 1'b1;
            q.rbuf  <= RST_DATA_BUF;
            q.baud_double <= RST_POWER_CTRL[PC_BAUD_DBL];
            q.pbits       <= RST_POWER_CTRL[4:0];
            {q.mode, q.mpc, q.ren, q.tx_ninth_bit,
             q.rx_ninth_bit, q.tx_done_flag,
             q.rx_done_flag} <= RST_SERIAL_CTRL;
            {q.tsel2, q.rsel2, q.six_t} <= RST_BAUD_SRC;
        end
        else
        begin
            q <= n;
        end
    end

    assign O_WB_DAT = {24'h000000, q.rdat};
    assign O_WB_ACK = q.ack;
    assign O_RXD    = q.rxd_o;
    assign O_RXD_OE = q.rxd_oe;
    assign O_TXD    = q.txd;

endmodule : sp_uart

// ---- tb/sp_uart_chk.sv ----
// Purpose: port checker for sp_uart
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every sp_uart instance
`timescale 1ns/1ps
module sp_uart_chk (
    // watched ports
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESETN,
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic [31:0] O_WB_DAT,
    input  wire logic        O_WB_ACK,
    input  wire logic        O_RXD,
    input  wire logic        O_RXD_OE,
    input  wire logic        O_TXD
);
    // length of the last drive burst on the receive pin
    logic [7:0] oe_cnt;
    always_ff @(posedge I_SYS_CLK)
    begin
        if (!I_RESETN || !O_RXD_OE)
            oe_cnt <= 8'h00;
        else
            oe_cnt <= oe_cnt + 8'h01;
    end
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESETN);
    a_ack_answers: assert property (
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("ack missing after request");
    a_ack_pulse: assert property (
        O_WB_ACK |=> !O_WB_ACK) else $error("ack longer than one cycle");
    a_rdat_quiet: assert property (
        !O_WB_ACK |-> O_WB_DAT == 32'h0) else $error("read data without ack");
    a_rdat_lane: assert property (
        O_WB_DAT[31:8] == 24'h0) else $error("upper read lanes not zero");
    a_reset_pins: assert property (disable iff (1'b0)
        !I_RESETN |=> O_TXD && !O_RXD_OE && !O_WB_ACK)
        else $error("pins not idle under reset");
    a_clk_half: assert property (
        $fell(O_TXD) && O_RXD_OE |->
        (!O_TXD[*6] ##1 O_TXD) or (!O_TXD[*3] ##1 O_TXD))
        else $error("shift clock low phase wrong");
    a_data_on_low: assert property (
        O_RXD_OE && $past(O_RXD_OE) && $changed(O_RXD) |-> $fell(O_TXD))
        else $error("shift data changed mid period");
    a_byte_len: assert property (
        $fell(O_RXD_OE) |-> oe_cnt == 8'h60 || oe_cnt == 8'h30)
        else $error("shift burst not eight periods");
    a_idle_after: assert property (
        $fell(O_RXD_OE) |-> O_TXD) else $error("clock not high after byte");
    c_m0_tx: cover property ($rose(O_RXD_OE));
    c_async: cover property ($fell(O_TXD) && !O_RXD_OE);
    c_read: cover property (O_WB_ACK && O_WB_DAT != 32'h0);
endmodule : sp_uart_chk

bind sp_uart sp_uart_chk chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .O_WB_DAT(O_WB_DAT),
    .O_WB_ACK(O_WB_ACK), .O_RXD(O_RXD), .O_RXD_OE(O_RXD_OE), .O_TXD(O_TXD));

// ---- tb/sp_far_end.sv ----
// Purpose: external serial partner of sp_uart
// Assumes: receive pin has a pull-up when nobody drives it
// Notes:   tasks are called from the testbench
`timescale 1ns/1ps
module sp_far_end (
    // pins
    input  wire logic i_clk,
    input  wire logic i_txd,
    input  wire logic i_rxd_dev,
    output logic      o_rxd,
    output logic      o_rxd_en
);
    initial
    begin
        o_rxd    = 1'b1;
        o_rxd_en = 1'b0;
    end
    // async frame, bit 0 first, then released to the pull-up
    task automatic send(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++)
        begin
            o_rxd    <= f[i];
            o_rxd_en <= 1'b1;
            repeat (per) @(posedge i_clk);
        end
        o_rxd_en <= 1'b0;
    endtask : send
    // samples each bit in its middle
    task automatic recv(input int n, input int per, output logic [10:0] f);
        f = 11'h000;
        @(negedge i_txd);
        repeat (per / 2) @(posedge i_clk);
        for (int i = 0; i < n; i++)
        begin
            f[i] = i_txd;
            repeat (per) @(posedge i_clk);
        end
    endtask : recv
    // clock follower only: never makes a shift clock of its own
    task automatic m0_take(output logic [7:0] b);
        b = 8'h00;
        repeat (8)
        begin
            @(posedge i_txd);
            b = {i_rxd_dev, b[7:1]};
        end
    endtask : m0_take
    task automatic m0_give(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
        begin
            @(negedge i_txd);
            o_rxd    <= b[i];
            o_rxd_en <= 1'b1;
        end
        @(posedge i_txd);
        @(posedge i_clk);
        o_rxd_en <= 1'b0;
    endtask : m0_give
endmodule : sp_far_end

// ---- tb/test_serial_port_modes_0_to_2.sv ----
// Purpose: self-checking bench for sp_uart
// Assumes: timer overflows pulse every second clock
// Notes:   register traffic over classic Wishbone
`timescale 1ns/1ps
module test_serial_port_modes_0_to_2
    import sp_pkg::*;
;
    logic        clk, rst_n, cyc, stb, we;
    logic        ovf = 1'b0;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic        ack, rxd_o, rxd_oe, txd, far_d, far_en, rxd_pin;
    logic [10:0] fr;
    logic [7:0]  rb;
    int          bad_count, tests_run;
    int          cycles = 0;
    // device drive wins, then partner, else pull-up
    assign rxd_pin = rxd_oe ? rxd_o : (far_en ? far_d : 1'b1);
    sp_uart dut_u (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc),
        .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_T1_OVF(ovf),
        .I_T2_OVF(ovf), .I_RXD(rxd_pin), .O_RXD(rxd_o), .O_RXD_OE(rxd_oe),
        .O_TXD(txd));
    sp_far_end far_u (.i_clk(clk), .i_txd(txd), .i_rxd_dev(rxd_o),
        .o_rxd(far_d), .o_rxd_en(far_en));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        ovf    <= ~ovf;
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            tally_and_finish;
        end
    end
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [7:0] q);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr
    task automatic chk(input string what, input logic [10:0] exp,
                       input logic [10:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp,
                       input string what);
        logic [7:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(what, {3'h0, exp}, {3'h0, q});
    endtask : rdc
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        {rst_n, cyc, stb, we} = 4'h0;
        adr = 10'h000;
        sel = 4'h1;
        wdat = 32'h0;
        {bad_count, tests_run} = {32'h0, 32'h0};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(IDX_DATA_BUF, RST_DATA_BUF, "data_buf_rst");
        rdc(IDX_POWER_CTRL, RST_POWER_CTRL, "power_rst");
        wr(IDX_POWER_CTRL, 8'hFF);
        rdc(IDX_POWER_CTRL, 8'h9F, "power_rw");
        wr(8'h10, 8'h5A);
        rdc(8'h10, 8'h00, "unmapped");
        $display("test registers done");
        wr(IDX_POWER_CTRL, 8'h00);
        wr(IDX_SERIAL_CTRL, 8'h88);
        fork
            far_u.recv(11, 64, fr);
            wr(IDX_DATA_BUF, 8'hA5);
        join
        chk("m2_frame", {2'b11, 8'hA5, 1'b0}, fr);
        chk("txd_idle", 11'h001, {10'h0, txd});
        rdc(IDX_SERIAL_CTRL, 8'h8A, "m2_tx_done");
        $display("test mode2 tx done");
        wr(IDX_POWER_CTRL, 8'h80);
        wr(IDX_SERIAL_CTRL, 8'h90);
        far_u.send({2'b11, 8'h3C, 1'b0}, 11, 32);
        rdc(IDX_SERIAL_CTRL, 8'h95, "m2_rx_flags");
        rdc(IDX_DATA_BUF, 8'h3C, "m2_rx_data");
        far_u.send({2'b11, 8'h55, 1'b0}, 11, 32);
        rdc(IDX_DATA_BUF, 8'h3C, "m2_rx_busy");
        wr(IDX_SERIAL_CTRL, 8'hB0);
        far_u.send({2'b10, 8'h66, 1'b0}, 11, 32);
        rdc(IDX_SERIAL_CTRL, 8'hB0, "m2_mpc_drop");
        far_u.send({2'b11, 8'h77, 1'b0}, 11, 32);
        rdc(IDX_DATA_BUF, 8'h77, "m2_mpc_take");
        $display("test mode2 rx done");
        wr(IDX_BAUD_SRC, 8'h04);
        wr(IDX_SERIAL_CTRL, 8'h50);
        fork
            far_u.recv(10, 32, fr);
            wr(IDX_DATA_BUF, 8'hC3);
        join
        chk("m1_frame", {2'b01, 8'hC3, 1'b0}, fr);
        far_u.send({2'b01, 8'h96, 1'b0}, 10, 32);
        rdc(IDX_SERIAL_CTRL, 8'h57, "m1_rx_flags");
        rdc(IDX_DATA_BUF, 8'h96, "m1_rx_data");
        wr(IDX_SERIAL_CTRL, 8'h70);
        far_u.send({2'b00, 8'h11, 1'b0}, 10, 32);
        rdc(IDX_SERIAL_CTRL, 8'h70, "m1_bad_stop");
        far_u.send({2'b01, 8'h22, 1'b0}, 10, 32);
        rdc(IDX_DATA_BUF, 8'h22, "m1_next");
        $display("test mode1 done");
        wr(IDX_BAUD_SRC, 8'h06);
        wr(IDX_SERIAL_CTRL, 8'hD8);
        fork
            far_u.recv(11, 32, fr);
            wr(IDX_DATA_BUF, 8'h5C);
        join
        chk("m3_frame", {2'b11, 8'h5C, 1'b0}, fr);
        far_u.send({2'b10, 8'hE1, 1'b0}, 11, 32);
        rdc(IDX_SERIAL_CTRL, 8'hDB, "m3_flags");
        rdc(IDX_DATA_BUF, 8'hE1, "m3_rx_data");
        $display("test mode3 done");
        wr(IDX_BAUD_SRC, 8'h00);
        wr(IDX_POWER_CTRL, 8'h00);
        wr(IDX_SERIAL_CTRL, 8'h00);
        fork
            far_u.m0_take(rb);
            wr(IDX_DATA_BUF, 8'h4D);
        join
        chk("m0_tx", {3'h0, 8'h4D}, {3'h0, rb});
        // last half period of the shift clock before the flag
        repeat (8) @(posedge clk);
        rdc(IDX_SERIAL_CTRL, 8'h02, "m0_tx_done");
        for (int k = 0; k < 2; k++)
        begin
            if (k > 0)
                wr(IDX_SERIAL_CTRL, 8'h10);
            wr(IDX_SERIAL_CTRL, 8'h00);
            fork
                far_u.m0_give(k > 0 ? 8'h5E : 8'hB2);
                wr(IDX_SERIAL_CTRL, 8'h10);
            join
            repeat (8) @(posedge clk);
            rdc(IDX_SERIAL_CTRL, 8'h11, "m0_rx_flags");
            rdc(IDX_DATA_BUF, k > 0 ? 8'h5E : 8'hB2, "m0_rx_data");
        end
        wr(IDX_BAUD_SRC, 8'h01);
        wr(IDX_SERIAL_CTRL, 8'h00);
        fork
            far_u.m0_take(rb);
            wr(IDX_DATA_BUF, 8'h93);
        join
        chk("m0_6t_tx", {3'h0, 8'h93}, {3'h0, rb});
        repeat (8) @(posedge clk);
        rdc(IDX_SERIAL_CTRL, 8'h02, "m0_6t_done");
        $display("test mode0 done");
        tally_and_finish;
    end
endmodule : test_serial_port_modes_0_to_2
